// ===== perf_stamp_pkg.sv
// Constants shared by the event counters and the cycle-stamp counter.
// Assumes one processor clock; model register indexes are flat 32-bit numbers.
package perf_stamp_pkg;

  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int unsigned STAMP_WIDTH = 64;
  localparam int unsigned HALF_WIDTH  = 32;
  localparam int unsigned SEL_WIDTH   = 64;
  localparam int unsigned EVENT_WIDTH = 8;

  // ------------------------------------------------------------------
  // Event-select fields
  // ------------------------------------------------------------------
  localparam int unsigned SEL_INT_BIT    = 20;
  localparam int unsigned SEL_EN_BIT     = 22;
  localparam int unsigned SEL_INV_BIT    = 23;
  localparam int unsigned SEL_THRESH_LSB = 24;
  localparam int unsigned SEL_THRESH_MSB = 31;
  // Reserved bits 63:42, 39:36 and 21 stay zero
  localparam logic [63:0] SEL_WRITE_MASK = 64'h0000_030F_FFDF_FFFF;
  localparam logic [63:0] SEL_RESET      = 64'h0000_0000_0000_0000;
  localparam logic [63:0] STAMP_RESET    = 64'h0000_0000_0000_0000;

  // ------------------------------------------------------------------
  // Model register indexes
  // ------------------------------------------------------------------
  localparam logic [31:0] STAMP_INDEX = 32'h0000_0100;
  localparam logic [31:0] SELECT_BASE = 32'h0000_0200;
  localparam logic [31:0] COUNT_BASE  = 32'h0000_0300;

  // ------------------------------------------------------------------
  // Identification query
  // ------------------------------------------------------------------
  localparam logic [31:0] ID_FUNC_BASIC   = 32'h0000_0001;
  localparam logic [31:0] ID_FUNC_EXT     = 32'h8000_0001;
  localparam int unsigned ID_STAMP_BIT    = 4;
  localparam int unsigned ID_STAMP_ID_BIT = 27;

  typedef enum logic [1:0] {
    RESP_NONE  = 2'b00,
    RESP_DATA  = 2'b01,
    RESP_FAULT = 2'b10
  } resp_kind_t;

endpackage : perf_stamp_pkg

// ===== event_counter_unit.sv
// One event-select register and its paired event counter.
// Assumes write strobes are already privilege-checked by the parent.
`timescale 1ns/1ns
module event_counter_unit #(
  parameter int unsigned COUNT_WIDTH = 48
) (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  // Register writes
  input  wire logic                   sel_wr,
  input  wire logic                   cnt_wr,
  input  wire logic [63:0]            wdata,
  // Events seen this clock
  input  wire logic [7:0]             events,
  // State
  output logic      [63:0]            event_select_reg,
  output logic      [COUNT_WIDTH-1:0] event_count_reg,
  output logic                        overflow_irq
);

  logic                   en;
  logic                   threshold_compare_invert;
  logic [7:0]             thresh;
  logic                   hit;
  logic [COUNT_WIDTH-1:0] inc;
  logic [COUNT_WIDTH:0]   sum;

  assign en     = event_select_reg[perf_stamp_pkg::SEL_EN_BIT];
  assign threshold_compare_invert    = event_select_reg[perf_stamp_pkg::SEL_INV_BIT];
  assign thresh = event_select_reg[perf_stamp_pkg::SEL_THRESH_MSB:
                                   perf_stamp_pkg::SEL_THRESH_LSB];
  assign hit    = threshold_compare_invert ? (events <= thresh) : (events >= thresh); // RULE19
  // Zero threshold counts every event rather than one per clock
  assign inc    = (thresh == 8'h00) ? COUNT_WIDTH'(events) : COUNT_WIDTH'(hit);
  assign sum    = {1'b0, event_count_reg} + {1'b0, inc};

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      event_select_reg <= perf_stamp_pkg::SEL_RESET;
    end else if (sel_wr) begin
      event_select_reg <= wdata & perf_stamp_pkg::SEL_WRITE_MASK; // RULE2
    end
  end

  // A counter write wins over counting in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      event_count_reg <= '0;
      overflow_irq    <= 1'b0;
    end else begin
      overflow_irq <= 1'b0;
      if (cnt_wr) begin
        event_count_reg <= wdata[COUNT_WIDTH-1:0]; // RULE20
      end else if (en) begin // RULE1
        event_count_reg <= sum[COUNT_WIDTH-1:0];
        overflow_irq    <= sum[COUNT_WIDTH] &&
                           event_select_reg[perf_stamp_pkg::SEL_INT_BIT]; // RULE4 RULE18
      end
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  property p_hold_when_off;
    @(posedge ref_clk) disable iff (!rst_n)
      (!en && !cnt_wr) |=> $stable(event_count_reg);
  endproperty
  a_hold_when_off: assert property (p_hold_when_off) // RULE1
    else $error("event counter moved while disabled");

  property p_step_on_hit;
    @(posedge ref_clk) disable iff (!rst_n)
      (en && !cnt_wr && thresh != 8'h00 && hit) |=>
        (event_count_reg == $past(event_count_reg) + COUNT_WIDTH'(1));
  endproperty
  a_step_on_hit: assert property (p_step_on_hit) // RULE19
    else $error("event counter missed a threshold hit");

  property p_irq_gated;
    @(posedge ref_clk) disable iff (!rst_n)
      overflow_irq |-> $past(event_select_reg[perf_stamp_pkg::SEL_INT_BIT]);
  endproperty
  a_irq_gated: assert property (p_irq_gated) // RULE18
    else $error("overflow interrupt without its enable");

endmodule : event_counter_unit

// ===== perf_stamp_counters.sv
// Event counters and the 64-bit cycle-stamp counter of one processor.
// Assumes the pipeline issues at most one access per cycle, inputs
// synchronous to ref_clk, and privilege already resolved into a level.
//
// Summary of operation
// [RULE1] Event counter counts only while enabled
// [RULE2] Counting starts and stops at write completion
// [RULE3] Software sets select fields before or with enable
// [RULE4] Overflow interrupts only when its enable set
// [RULE5] Handler may reload counter preset before returning
// [RULE6] Reset clears the cycle-stamp counter to zero
// [RULE7] Stamp counter adds one every clock
// [RULE8] Each stamp read exceeds the previous read
// [RULE9] Stamp counter is 64 bits, wraps to zero
// [RULE10] Upper half to high result, lower to low
// [RULE11] Disable bit plus nonzero privilege faults reads
// [RULE12] Otherwise stamp reads work at every level
// [RULE13] Query reports stamp bit 4, id-read bit 27
// [RULE14] Model register path to stamp is optional
// [RULE15] Plain read unordered; id variant serializes
// [RULE16] Stamp advances at constant clock rate
// [RULE17] Enable at select bit 22 gates the pair
// [RULE18] Interrupt enable at select bit 20
// [RULE19] Count only when events meet the threshold
// [RULE20] Disabled counter holds value, stays accessible
`timescale 1ns/1ns
module perf_stamp_counters #(
  parameter int unsigned NUM_COUNTERS = 4,
  parameter int unsigned COUNT_WIDTH  = 48
) (
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  // Processor state
  input  wire logic [1:0]                current_privilege_level,
  input  wire logic                      stamp_read_disable,
  // Stamp read instructions
  input  wire logic                      stamp_rd_req,
  input  wire logic                      stamp_rd_with_id,
  // Model register access
  input  wire logic                      mreg_rd,
  input  wire logic                      mreg_wr,
  input  wire logic [31:0]               mreg_addr,
  input  wire logic [63:0]               mreg_wdata,
  // Identification query
  input  wire logic                      id_req,
  input  wire logic [31:0]               id_func,
  // Event sources, one byte per counter
  input  wire logic [NUM_COUNTERS*8-1:0] event_in,
  // Results
  output logic                           result_valid,
  output logic                           general_protection_fault,
  output logic      [31:0]               high_result_reg,
  output logic      [31:0]               low_result_reg,
  output logic                           serialize_req,
  // Counter state
  output logic      [63:0]               cycle_stamp_count,
  output logic      [NUM_COUNTERS-1:0]   overflow_irq
);

  localparam int unsigned IDX_W = (NUM_COUNTERS > 1) ? $clog2(NUM_COUNTERS) : 1;

  // ------------------------------------------------------------------
  // Parameter checks
  // ------------------------------------------------------------------
  if (NUM_COUNTERS < 1 || NUM_COUNTERS > 256) begin : g_bad_num
    $error("NUM_COUNTERS must be 1 to 256");
  end
  if (COUNT_WIDTH < 2 || COUNT_WIDTH > 64) begin : g_bad_width
    $error("COUNT_WIDTH must be 2 to 64");
  end

  // ------------------------------------------------------------------
  // Cycle-stamp counter
  // ------------------------------------------------------------------
  // One increment per ref_clk; any rate change must come from the clock
  // itself, which this block cannot see.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cycle_stamp_count <= perf_stamp_pkg::STAMP_RESET; // RULE6
    end else begin
      cycle_stamp_count <= cycle_stamp_count + 64'h0000_0000_0000_0001; // RULE7 RULE9 RULE16
    end
  end

  // ------------------------------------------------------------------
  // Request selection and address decode
  // ------------------------------------------------------------------
  logic             priv_zero;
  logic             stamp_blocked;
  logic             take_stamp;
  logic             take_mreg;
  logic             take_id;
  logic             sel_hit;
  logic             cnt_hit;
  logic             stamp_hit;
  logic [IDX_W-1:0] reg_idx;
  logic [31:0]      sel_off;
  logic [31:0]      cnt_off;
  logic             mreg_ok;

  assign priv_zero     = (current_privilege_level == 2'b00);
  // No mode input at all: only the disable bit and privilege gate reads
  assign stamp_blocked = stamp_read_disable && !priv_zero; // RULE11 RULE12
  assign take_stamp    = stamp_rd_req;
  assign take_mreg     = !stamp_rd_req && (mreg_rd || mreg_wr);
  assign take_id       = !stamp_rd_req && !mreg_rd && !mreg_wr && id_req;
  assign sel_off       = mreg_addr - perf_stamp_pkg::SELECT_BASE;
  assign cnt_off       = mreg_addr - perf_stamp_pkg::COUNT_BASE;

  always_comb begin
    sel_hit   = 1'b0;
    cnt_hit   = 1'b0;
    stamp_hit = 1'b0;
    reg_idx   = '0;
    if (mreg_addr == perf_stamp_pkg::STAMP_INDEX) begin
      stamp_hit = 1'b1;
    end else if (mreg_addr >= perf_stamp_pkg::SELECT_BASE &&
                 sel_off < 32'(NUM_COUNTERS)) begin
      sel_hit = 1'b1;
      reg_idx = sel_off[IDX_W-1:0];
    end else if (mreg_addr >= perf_stamp_pkg::COUNT_BASE &&
                 cnt_off < 32'(NUM_COUNTERS)) begin
      cnt_hit = 1'b1;
      reg_idx = cnt_off[IDX_W-1:0];
    end
  end

  // Stamp is read-only on this path; its write is refused with a fault
  assign mreg_ok = priv_zero && (sel_hit || cnt_hit || (stamp_hit && mreg_rd)); // RULE14

  // ------------------------------------------------------------------
  // Event counter array
  // ------------------------------------------------------------------
  logic [63:0]            sel_q [NUM_COUNTERS];
  logic [COUNT_WIDTH-1:0] cnt_q [NUM_COUNTERS];

  for (genvar i = 0; i < NUM_COUNTERS; i++) begin : g_ctr
    logic sel_wr;
    logic cnt_wr;
    // A whole select word lands in one write, so fields and enable agree
    assign sel_wr = take_mreg && mreg_wr && mreg_ok && sel_hit &&
                    (reg_idx == IDX_W'(i)); // RULE3 RULE17
    // Counter may be reloaded at any time, running or not
    assign cnt_wr = take_mreg && mreg_wr && mreg_ok && cnt_hit &&
                    (reg_idx == IDX_W'(i)); // RULE5 RULE20
    event_counter_unit #(
      .COUNT_WIDTH (COUNT_WIDTH)
    ) u_unit (
      .ref_clk          (ref_clk),
      .rst_n            (rst_n),
      .sel_wr           (sel_wr),
      .cnt_wr           (cnt_wr),
      .wdata            (mreg_wdata),
      .events           (event_in[i*8 +: 8]),
      .event_select_reg (sel_q[i]),
      .event_count_reg  (cnt_q[i]),
      .overflow_irq     (overflow_irq[i])
    );
  end

  // ------------------------------------------------------------------
  // Read data and identification value
  // ------------------------------------------------------------------
  logic [63:0] read_data;
  logic [31:0] id_value;

  always_comb begin
    read_data = 64'h0000_0000_0000_0000;
    if (stamp_hit) begin
      read_data = cycle_stamp_count;
    end else if (sel_hit) begin
      read_data = sel_q[reg_idx];
    end else if (cnt_hit) begin
      read_data = 64'(cnt_q[reg_idx]);
    end
  end

  always_comb begin
    id_value = 32'h0000_0000;
    if (id_func == perf_stamp_pkg::ID_FUNC_BASIC) begin
      id_value[perf_stamp_pkg::ID_STAMP_BIT] = 1'b1; // RULE13
    end else if (id_func == perf_stamp_pkg::ID_FUNC_EXT) begin
      id_value[perf_stamp_pkg::ID_STAMP_ID_BIT] = 1'b1; // RULE13
    end
  end

  // ------------------------------------------------------------------
  // Result stage
  // ------------------------------------------------------------------
  perf_stamp_pkg::resp_kind_t resp_kind;
  perf_stamp_pkg::resp_kind_t next_resp_kind;
  logic [31:0]                next_high;
  logic [31:0]                next_low;
  logic                       next_serialize;

  always_comb begin
    next_resp_kind = perf_stamp_pkg::RESP_NONE;
    next_high      = high_result_reg;
    next_low       = low_result_reg;
    next_serialize = 1'b0;
    if (take_stamp) begin
      // Plain read is not ordered against neighbours; id variant is
      next_serialize = stamp_rd_with_id; // RULE15
      if (stamp_blocked) begin
        next_resp_kind = perf_stamp_pkg::RESP_FAULT; // RULE11
      end else begin
        next_resp_kind = perf_stamp_pkg::RESP_DATA;
        next_high      = cycle_stamp_count[63:32]; // RULE10
        next_low       = cycle_stamp_count[31:0]; // RULE10
      end
    end else if (take_mreg) begin
      if (!mreg_ok) begin
        next_resp_kind = perf_stamp_pkg::RESP_FAULT;
      end else begin
        next_resp_kind = perf_stamp_pkg::RESP_DATA;
        if (mreg_rd) begin
          next_high = read_data[63:32];
          next_low  = read_data[31:0];
        end
      end
    end else if (take_id) begin
      next_resp_kind = perf_stamp_pkg::RESP_DATA;
      next_high      = id_value;
      next_low       = 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      resp_kind       <= perf_stamp_pkg::RESP_NONE;
      high_result_reg <= 32'h0000_0000;
      low_result_reg  <= 32'h0000_0000;
      serialize_req   <= 1'b0;
    end else begin
      resp_kind       <= next_resp_kind;
      high_result_reg <= next_high;
      low_result_reg  <= next_low;
      serialize_req   <= next_serialize;
    end
  end

  assign result_valid             = (resp_kind != perf_stamp_pkg::RESP_NONE);
  assign general_protection_fault = (resp_kind == perf_stamp_pkg::RESP_FAULT);

  // ------------------------------------------------------------------
  // Assertion helpers
  // ------------------------------------------------------------------
  logic        stamp_data_out;
  logic        have_prev;
  logic [63:0] prev_stamp_read;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stamp_data_out  <= 1'b0;
      have_prev       <= 1'b0;
      prev_stamp_read <= 64'h0000_0000_0000_0000;
    end else begin
      stamp_data_out <= take_stamp && !stamp_blocked;
      if (stamp_data_out) begin
        have_prev       <= 1'b1;
        prev_stamp_read <= {high_result_reg, low_result_reg};
      end
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  property p_stamp_after_reset;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(rst_n) |-> (cycle_stamp_count == 64'h0000_0000_0000_0000);
  endproperty
  a_stamp_after_reset: assert property (p_stamp_after_reset) // RULE6
    else $error("stamp not zero after reset");

  property p_stamp_step;
    @(posedge ref_clk) disable iff (!rst_n)
      $past(rst_n) |-> (cycle_stamp_count ==
                        $past(cycle_stamp_count) + 64'h0000_0000_0000_0001);
  endproperty
  a_stamp_step: assert property (p_stamp_step) // RULE7
    else $error("stamp did not advance by one");

  sequence s_open_read;
    stamp_rd_req && !stamp_blocked;
  endsequence
  sequence s_read_data;
    ##1 (result_valid && !general_protection_fault);
  endsequence
  property p_read_halves;
    @(posedge ref_clk) disable iff (!rst_n)
      s_open_read |-> s_read_data ##0
        ({high_result_reg, low_result_reg} == $past(cycle_stamp_count));
  endproperty
  a_read_halves: assert property (p_read_halves) // RULE10
    else $error("stamp halves returned wrongly");

  property p_blocked_fault;
    @(posedge ref_clk) disable iff (!rst_n)
      (stamp_rd_req && stamp_read_disable && current_privilege_level != 2'b00)
        |=> (result_valid && general_protection_fault);
  endproperty
  a_blocked_fault: assert property (p_blocked_fault) // RULE11
    else $error("blocked stamp read did not fault");

  property p_user_read_ok;
    @(posedge ref_clk) disable iff (!rst_n)
      (stamp_rd_req && !stamp_read_disable) |=> !general_protection_fault;
  endproperty
  a_user_read_ok: assert property (p_user_read_ok) // RULE12
    else $error("enabled stamp read faulted");

  property p_monotonic;
    @(posedge ref_clk) disable iff (!rst_n)
      (stamp_data_out && have_prev) |->
        ({high_result_reg, low_result_reg} > prev_stamp_read);
  endproperty
  a_monotonic: assert property (p_monotonic) // RULE8
    else $error("stamp read not larger than previous");

  property p_id_bits;
    @(posedge ref_clk) disable iff (!rst_n)
      (!stamp_rd_req && !mreg_rd && !mreg_wr && id_req &&
       id_func == perf_stamp_pkg::ID_FUNC_BASIC)
        |=> (result_valid && high_result_reg == 32'h0000_0010);
  endproperty
  a_id_bits: assert property (p_id_bits) // RULE13
    else $error("identification bit for stamp missing");

  property p_serialize;
    @(posedge ref_clk) disable iff (!rst_n)
      serialize_req |-> ($past(stamp_rd_req) && $past(stamp_rd_with_id));
  endproperty
  a_serialize: assert property (p_serialize) // RULE15
    else $error("serialize without id read");

  property p_enable_starts;
    @(posedge ref_clk) disable iff (!rst_n)
      (take_mreg && mreg_wr && priv_zero && sel_hit &&
       mreg_wdata[perf_stamp_pkg::SEL_EN_BIT])
        |=> sel_q[$past(reg_idx)][perf_stamp_pkg::SEL_EN_BIT];
  endproperty
  a_enable_starts: assert property (p_enable_starts) // RULE2
    else $error("enable write did not take effect");

endmodule : perf_stamp_counters

// ===== pipe_model.sv
// Pipeline stand-in: turns one bench command into one request cycle.
// Assumes commands arrive at most one per op and are spaced by the bench.
`timescale 1ns/1ns
module pipe_model (
  // Clock
  input  wire logic        ref_clk,
  // Bench command
  input  wire logic        go,
  input  wire logic [1:0]  kind,
  input  wire logic [31:0] addr,
  input  wire logic [63:0] wdata,
  // Requests to the counters
  output logic             stamp_rd_req,
  output logic             stamp_rd_with_id,
  output logic             mreg_rd,
  output logic             mreg_wr,
  output logic [31:0]      mreg_addr,
  output logic [63:0]      mreg_wdata,
  output logic             id_req,
  output logic [31:0]      id_func
);
  // ------------------------------------------------------------------
  // Request launch
  // ------------------------------------------------------------------
  initial begin
    {stamp_rd_req, stamp_rd_with_id, mreg_rd, mreg_wr, id_req} = 5'h00;
    {mreg_addr, id_func, mreg_wdata} = 128'h0;
  end
  // Idle address, data and id fields flip while request strobes drop, so stale values are never mistaken for live ones
  always @(posedge ref_clk) begin
    stamp_rd_req     <= go && kind == 2'd0;
    stamp_rd_with_id <= go ? addr[0] : ~stamp_rd_with_id;
    mreg_rd          <= go && kind == 2'd1;
    mreg_wr          <= go && kind == 2'd2;
    id_req           <= go && kind == 2'd3;
    mreg_addr        <= go ? addr : ~mreg_addr;
    mreg_wdata       <= go ? wdata : ~mreg_wdata;
    id_func          <= go ? addr : ~id_func;
  end
endmodule : pipe_model

// ===== test_perf_stamp_counters.sv
// Self-checking bench for the event and cycle-stamp counters.
// Assumes pipe_model as the request source; one op in flight at a time.
`timescale 1ns/1ns
module test_perf_stamp_counters;
  localparam int unsigned NC = 4;
  localparam int unsigned CW = 48;
  logic            ref_clk = 1'b0;
  logic            rst_n = 1'b0;
  logic [1:0]      priv = 2'd0;
  logic            dis = 1'b0;
  logic            go = 1'b0;
  logic [1:0]      kind = 2'd0;
  logic [31:0]     addr = 32'h0000_0000;
  logic [63:0]     wdata = 64'h0;
  logic [NC*8-1:0] event_in = '0;
  logic stamp_rd_req, stamp_rd_with_id, mreg_rd, mreg_wr, id_req;
  logic result_valid, general_protection_fault, serialize_req;
  logic [31:0] mreg_addr, id_func, high_result_reg, low_result_reg;
  logic [63:0] mreg_wdata, cycle_stamp_count;
  logic [NC-1:0] overflow_irq;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int req_cyc = 0;
  int prev_cyc = 0;
  int st_base = 0;
  int ovf_exp[NC] = '{default: 0};
  int ovf_got[NC] = '{default: 0};
  logic [63:0] ref_sel[NC];
  logic [CW-1:0] ref_cnt[NC];
  logic [63:0] sel[NC];
  logic [63:0] prev_st;
  logic [31:0] r_hi, r_lo;
  logic r_flt, r_ser;

  pipe_model pipe_u (.ref_clk, .go, .kind, .addr, .wdata, .stamp_rd_req, .stamp_rd_with_id,
    .mreg_rd, .mreg_wr, .mreg_addr, .mreg_wdata, .id_req, .id_func);
  perf_stamp_counters #(.NUM_COUNTERS(NC), .COUNT_WIDTH(CW)) dut_u (.ref_clk, .rst_n,
    .current_privilege_level(priv), .stamp_read_disable(dis), .stamp_rd_req,
    .stamp_rd_with_id, .mreg_rd, .mreg_wr, .mreg_addr, .mreg_wdata, .id_req, .id_func,
    .event_in, .result_valid, .general_protection_fault, .high_result_reg, .low_result_reg,
    .serialize_req, .cycle_stamp_count, .overflow_irq);

  always #2 ref_clk = ~ref_clk;

  // ------------------------------------------------------------------
  // Reference counters, fed from what the counters actually take
  // ------------------------------------------------------------------
  function automatic logic [7:0] inc(input logic [7:0] ev, input logic [63:0] s);
    if (s[31:24] == 8'h00) return ev;
    return (s[23] ? ev <= s[31:24] : ev >= s[31:24]) ? 8'h01 : 8'h00;
  endfunction : inc

  always @(posedge ref_clk) begin
    cyc++;
    event_in <= $urandom;
    if (stamp_rd_req === 1'b1 || mreg_rd === 1'b1) req_cyc = cyc;
    // Stamp reads zero at the first edge with reset released
    if (!rst_n) st_base = cyc + 1;
    else chk_val(cycle_stamp_count, 64'(cyc - st_base));
    for (int i = 0; i < NC; i++) begin
      logic [CW:0] nxt;
      nxt = {1'b0, ref_cnt[i]} + inc(event_in[i*8+:8], ref_sel[i]);
      if (ref_sel[i][22] && nxt[CW] && ref_sel[i][20]) ovf_exp[i]++;
      if (ref_sel[i][22]) ref_cnt[i] = nxt[CW-1:0];
      if (mreg_wr && priv == 2'd0 && mreg_addr == perf_stamp_pkg::SELECT_BASE + 32'(i))
        ref_sel[i] = mreg_wdata & perf_stamp_pkg::SEL_WRITE_MASK;
      if (mreg_wr && priv == 2'd0 && mreg_addr == perf_stamp_pkg::COUNT_BASE + 32'(i))
        ref_cnt[i] = mreg_wdata[CW-1:0];
      if (!rst_n) begin
        ref_sel[i] = 64'h0;
        ref_cnt[i] = '0;
      end
      if (overflow_irq[i] === 1'b1) ovf_got[i]++;
    end
    if (cyc == 5000) begin
      n_errors++;
      close_out();
    end
  end

  // ------------------------------------------------------------------
  // Compare, op and report tasks
  // ------------------------------------------------------------------
  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  // Kinds: 0 stamp read, 1 reg read, 2 reg write, 3 id query
  task automatic op(input logic [1:0] k, input logic [31:0] a, input logic [63:0] d);
    go <= 1'b1;
    kind <= k;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    go <= 1'b0;
    r_flt = 1'bx;
    for (int w = 0; w < 8; w++) begin
      @(posedge ref_clk);
      if (result_valid === 1'b1) begin
        r_hi = high_result_reg;
        r_lo = low_result_reg;
        r_flt = general_protection_fault;
        r_ser = serialize_req;
        break;
      end
    end
  endtask : op

  task automatic stamp_chk(input logic [1:0] p, input logic d, input logic wid);
    logic f;
    f = d && p != 2'd0;
    priv <= p;
    dis <= d;
    op(2'd0, {31'h0000_0000, wid}, 64'h0);
    chk_bit(r_flt, f);
    if (!f) begin
      chk_bit(r_ser, wid);
      chk_val({r_hi, r_lo} - prev_st, 64'(req_cyc - prev_cyc));
      prev_st = {r_hi, r_lo};
      prev_cyc = req_cyc;
    end
  endtask : stamp_chk

  task automatic close_out();
    $display("errors %0d, comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(50923));
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    op(2'd0, 32'h0000_0000, 64'h0);
    chk_bit({r_hi, r_lo} < 64'h0000_0000_0000_0010, 1'b1);
    prev_st = {r_hi, r_lo};
    prev_cyc = req_cyc;
    for (int i = 0; i < 16; i++) stamp_chk(2'(i), i[2], 1'($urandom));
    priv <= 2'd0;
    dis <= 1'b0;
    op(2'd3, perf_stamp_pkg::ID_FUNC_BASIC, 64'h0);
    chk_bit(r_hi[perf_stamp_pkg::ID_STAMP_BIT], 1'b1);
    op(2'd3, perf_stamp_pkg::ID_FUNC_EXT, 64'h0);
    chk_bit(r_hi[perf_stamp_pkg::ID_STAMP_ID_BIT], 1'b1);
    op(2'd2, perf_stamp_pkg::STAMP_INDEX, 64'h1);
    chk_bit(r_flt, 1'b1);
    op(2'd1, 32'h0000_0400, 64'h0);
    chk_bit(r_flt, 1'b1);
    op(2'd1, perf_stamp_pkg::STAMP_INDEX, 64'h0);
    chk_bit(r_flt, 1'b0);
    chk_val({r_hi, r_lo}, 64'(req_cyc - st_base));
    priv <= 2'd1;
    op(2'd1, perf_stamp_pkg::SELECT_BASE, 64'h0);
    chk_bit(r_flt, 1'b1);
    priv <= 2'd0;
    // Presets just below the top so both wrap within the run
    op(2'd2, perf_stamp_pkg::COUNT_BASE, 64'h0000_FFFF_FFFF_FFF0);
    op(2'd2, perf_stamp_pkg::COUNT_BASE + 32'h1, 64'h0000_FFFF_FFFF_FFF0);
    sel[0] = 64'hFFFF_FFFF_0150_0000;
    sel[1] = 64'h0000_0000_0140_0000;
    sel[2] = {32'h0000_0000, 8'($urandom), 8'hC0, 16'h0000};
    sel[3] = 64'h0000_0000_0040_00FF;
    for (int i = 0; i < NC; i++) begin
      op(2'd2, perf_stamp_pkg::SELECT_BASE + 32'(i), sel[i]);
      op(2'd1, perf_stamp_pkg::SELECT_BASE + 32'(i), 64'h0);
      chk_val({r_hi, r_lo}, sel[i] & perf_stamp_pkg::SEL_WRITE_MASK);
    end
    repeat (40) @(posedge ref_clk);
    for (int i = 0; i < NC; i++) op(2'd2, perf_stamp_pkg::SELECT_BASE + 32'(i),
      sel[i] & ~(64'h1 << perf_stamp_pkg::SEL_EN_BIT));
    for (int i = 0; i < NC; i++) begin
      op(2'd1, perf_stamp_pkg::COUNT_BASE + 32'(i), 64'h0);
      chk_val({r_hi, r_lo}, 64'(ref_cnt[i]));
    end
    repeat (10) @(posedge ref_clk);
    op(2'd1, perf_stamp_pkg::COUNT_BASE + 32'h3, 64'h0);
    chk_val({r_hi, r_lo}, 64'(ref_cnt[3]));
    chk_val(64'(ovf_got[0]), 64'(ovf_exp[0]));
    chk_val(64'(ovf_got[1]), 64'h0);
    for (int i = 0; i < NC; i++) chk_val(64'(ovf_got[i]), 64'(ovf_exp[i]));
    close_out();
  end
endmodule : test_perf_stamp_counters
